// ===== hw/ext_irq_and_vector_table.v
// Behaviour
// - Any reset cause vectors to word zero
// - Line A 0x01, pin change 0x02, B 0x0D
// - Timer B match A/B, overflow 0x03-0x05
// - Timer A overflow 0x06, matches 0x0E/0x0F
// - Serial start/overflow, memory ready 0x07-0x09
// - Comparator, converter, watchdog 0x0A-0x0C
// - Capture, match D, fault 0x10-0x12
// - Pins trigger even when driven as outputs
// - Any unmasked pin toggle raises pin change
// - Pin change detected only with ref_clk_i running
// - Lines sense falling, rising or low level
// - Low level requests while pin stays low
// - Edge detection needs running I/O clock
// - Line A low level detected through the ref_clk_i samplers
// - Level must outlast start-up for interrupt
// - Control register layout, reset zero, read-only bits
// - Sense field: low, change, fall, rise
// - Pulses over two clocks always caught
// - Flags clear on entry or written one
//
// Chosen here: the AXI4-Lite slave port.
`include "ext_irq_consts.vh"

module ext_irq_and_vector_table (
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_b_i,
  // AXI4-Lite slave
  input wire [11:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [11:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  // Pins, sampled whatever their direction
  input wire ext_req_line_a_i,
  input wire ext_req_line_b_i,
  input wire [15:0] pin_change_inputs_i,
  // Reset causes and peripheral requests
  input wire [3:0] reset_cause_i,
  input wire [15:0] periph_req_i,
  // Core side
  input wire global_irq_en_i,
  input wire irq_ack_i,
  output reg irq_req_o,
  output reg [4:0] irq_vector_o,
  output reg [4:0] fetch_addr_o,
  output reg wake_o,
  output reg [6:0] mcu_control_o
);

  // ****************************************
  // Helpers
  // ****************************************
  function settle3;
    input [2:0] s;
    input old;
    begin
      settle3 = (s[2] == s[1]) ? s[1] : old;
    end
  endfunction

  // ****************************************
  // Registers
  // ****************************************
  reg [7:0] mcu_control_reg;
  reg [2:0] req_enable_reg;
  reg [15:0] pc_mask_reg;
  reg flag_a_reg, flag_b_reg, flag_pc_reg;
  reg [2:0] sync_a_reg, sync_b_reg;
  reg [15:0] pc_s0_reg, pc_s1_reg, pc_s2_reg, pc_last_reg;
  reg last_a_reg, last_b_reg;
  reg aw_hold_reg, w_hold_reg;
  reg [11:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;

  wire [1:0] sense = mcu_control_reg[`BIT_SENSE_HI:`BIT_SENSE_LO];
  wire a_now = settle3(sync_a_reg, last_a_reg);
  wire b_now = settle3(sync_b_reg, last_b_reg);
  wire [15:0] pc_now;
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_pc
      assign pc_now[g] = settle3({pc_s2_reg[g], pc_s1_reg[g], pc_s0_reg[g]}, pc_last_reg[g]);
    end
  endgenerate

  // ****************************************
  // Edge and level sensing
  // ****************************************
  function edge_hit;
    input [1:0] mode;
    input now;
    input last;
    begin
      case (mode)
        `SENSE_ANY: edge_hit = now ^ last;
        `SENSE_FALL: edge_hit = last & ~now;
        `SENSE_RISE: edge_hit = now & ~last;
        default: edge_hit = 1'b0;
      endcase
    end
  endfunction

  wire hit_a = edge_hit(sense, a_now, last_a_reg);
  wire hit_b = edge_hit(sense, b_now, last_b_reg);
  wire level_mode = (sense == `SENSE_LOW);
  wire level_a = level_mode & ~a_now;
  wire level_b = level_mode & ~b_now;
  wire hit_pc = |((pc_now ^ pc_last_reg) & pc_mask_reg);

  // ****************************************
  // Request priority
  // ****************************************
  wire [18:0] pending;
  assign pending[0] = flag_a_reg & req_enable_reg[1] | level_a & req_enable_reg[1];
  assign pending[1] = flag_pc_reg & req_enable_reg[0];
  assign pending[11:2] = periph_req_i[9:0];
  assign pending[12] = flag_b_reg & req_enable_reg[2] | level_b & req_enable_reg[2];
  assign pending[18:13] = periph_req_i[15:10];

  reg [4:0] pick;
  reg any;
  integer i;
  always @* begin
    pick = `VEC_RESET;
    any = 1'b0;
    for (i = 18; i >= 0; i = i - 1) begin
      if (pending[i]) begin
        pick = i[4:0] + 5'd1;
        any = 1'b1;
      end
    end
  end

  wire ack_a = irq_ack_i & (irq_vector_o == `VEC_LINE_A);
  wire ack_b = irq_ack_i & (irq_vector_o == `VEC_LINE_B);
  wire ack_pc = irq_ack_i & (irq_vector_o == `VEC_PIN_CHANGE);

  // ****************************************
  // AXI4-Lite write decode
  // ****************************************
  wire do_write = aw_hold_reg & w_hold_reg & ~s_axi_bvalid_o;
  wire wr_ctl = do_write & (awaddr_reg == `ADDR_MCU_CONTROL) & wstrb_reg[0];
  wire wr_en = do_write & (awaddr_reg == `ADDR_REQ_ENABLE) & wstrb_reg[0];
  wire wr_flg = do_write & (awaddr_reg == `ADDR_REQ_FLAGS) & wstrb_reg[0];
  wire wr_msk = do_write & (awaddr_reg == `ADDR_PC_MASK);
  wire w_ok = (awaddr_reg == `ADDR_MCU_CONTROL) | (awaddr_reg == `ADDR_REQ_ENABLE) |
              (awaddr_reg == `ADDR_REQ_FLAGS) | (awaddr_reg == `ADDR_PC_MASK) |
              (awaddr_reg == `ADDR_STATUS);
  wire clr_a = wr_flg & wdata_reg[`BIT_EN_LINE_A];
  wire clr_b = wr_flg & wdata_reg[`BIT_EN_LINE_B];
  wire clr_pc = wr_flg & wdata_reg[`BIT_EN_PC];

  // ****************************************
  // Pin sampling and flags
  // ****************************************
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flag_a_reg <= 1'b0;
      flag_b_reg <= 1'b0;
      flag_pc_reg <= 1'b0;
      sync_a_reg <= 3'b111;
      sync_b_reg <= 3'b111;
      pc_s0_reg <= 16'h0000;
      pc_s1_reg <= 16'h0000;
      pc_s2_reg <= 16'h0000;
      pc_last_reg <= 16'h0000;
      last_a_reg <= 1'b1;
      last_b_reg <= 1'b1;
    end else begin
      // Pin samplers run whatever the pin direction
      sync_a_reg <= {sync_a_reg[1:0], ext_req_line_a_i};
      sync_b_reg <= {sync_b_reg[1:0], ext_req_line_b_i};
      pc_s0_reg <= pin_change_inputs_i;
      pc_s1_reg <= pc_s0_reg;
      pc_s2_reg <= pc_s1_reg;
      pc_last_reg <= pc_now;
      last_a_reg <= a_now;
      last_b_reg <= b_now;
      // Flags: set beats clear, level mode holds edge flags clear
      flag_a_reg <= ~level_mode & (hit_a | (flag_a_reg & ~clr_a & ~ack_a));
      flag_b_reg <= ~level_mode & (hit_b | (flag_b_reg & ~clr_b & ~ack_b));
      flag_pc_reg <= hit_pc | (flag_pc_reg & ~clr_pc & ~ack_pc);
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mcu_control_reg <= `MCU_CONTROL_RST;
      req_enable_reg <= 3'b000;
      pc_mask_reg <= `PC_MASK_RST;
    end else begin
      if (wr_ctl)
        mcu_control_reg <= wdata_reg[7:0] & `MCU_CONTROL_WMASK;
      if (wr_en)
        req_enable_reg <= wdata_reg[7:5];
      if (wr_msk) begin
        if (wstrb_reg[0])
          pc_mask_reg[7:0] <= wdata_reg[7:0];
        if (wstrb_reg[1])
          pc_mask_reg[15:8] <= wdata_reg[15:8];
      end
    end
  end

  // ****************************************
  // Write channel
  // ****************************************
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= 2'b00;
    end else begin
      // Address and data are taken in either order
      s_axi_awready_o <= ~aw_hold_reg & ~s_axi_awready_o;
      s_axi_wready_o <= ~w_hold_reg & ~s_axi_wready_o;
      if (s_axi_awvalid_i & s_axi_awready_o) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i & s_axi_wready_o) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata_i;
        wstrb_reg <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= w_ok ? 2'b00 : 2'b10;
      end
      if (s_axi_bvalid_o & s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rresp_o <= 2'b00;
      s_axi_rdata_o <= 32'h0000_0000;
    end else begin
      s_axi_arready_o <= ~s_axi_rvalid_o & ~s_axi_arready_o;
      if (s_axi_arvalid_i & s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o <= 2'b00;
        case (s_axi_araddr_i)
          `ADDR_MCU_CONTROL: s_axi_rdata_o <= {24'h00_0000, mcu_control_reg};
          `ADDR_REQ_ENABLE: s_axi_rdata_o <= {24'h00_0000, req_enable_reg, 5'h00};
          `ADDR_REQ_FLAGS: s_axi_rdata_o <= {24'h00_0000, flag_b_reg, flag_a_reg, flag_pc_reg, 5'h00};
          `ADDR_PC_MASK: s_axi_rdata_o <= {16'h0000, pc_mask_reg};
          `ADDR_STATUS: s_axi_rdata_o <= {9'h000, pc_now, b_now, a_now, irq_vector_o};
          default: begin
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= 2'b10;
          end
        endcase
      end
      if (s_axi_rvalid_o & s_axi_rready_i)
        s_axi_rvalid_o <= 1'b0;
    end
  end

  // ****************************************
  // Core request and vector
  // ****************************************
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_req_o <= 1'b0;
      irq_vector_o <= `VEC_RESET;
      fetch_addr_o <= `VEC_RESET;
      wake_o <= 1'b0;
      mcu_control_o <= 7'h00;
    end else begin
      irq_req_o <= any & global_irq_en_i & ~irq_ack_i;
      irq_vector_o <= pick;
      fetch_addr_o <= (|reset_cause_i) ? `VEC_RESET : pick;
      wake_o <= hit_pc | level_a;
      mcu_control_o <= mcu_control_reg[6:0];
    end
  end

endmodule // ext_irq_and_vector_table

// ===== hw/ext_irq_consts.vh
`ifndef EXT_IRQ_CONSTS_VH
`define EXT_IRQ_CONSTS_VH

// ****************************************
// Register byte addresses
// ****************************************
// Control register stands at index 0x35, byte address four times that
`define MCU_CONTROL_IDX 8'h35
`define ADDR_MCU_CONTROL 12'h0d4
`define ADDR_REQ_ENABLE 12'h100
`define ADDR_REQ_FLAGS 12'h104
`define ADDR_PC_MASK 12'h108
`define ADDR_STATUS 12'h10c

// ****************************************
// Field positions and reset values
// ****************************************
`define MCU_CONTROL_RST 8'h00
`define MCU_CONTROL_WMASK 8'h7b
`define BIT_PULLUP_OFF 6
`define BIT_SLEEP_ALLOW 5
`define BIT_SLEEP_KIND_HI 4
`define BIT_SLEEP_KIND_LO 3
`define BIT_SENSE_HI 1
`define BIT_SENSE_LO 0
`define BIT_EN_LINE_B 7
`define BIT_EN_LINE_A 6
`define BIT_EN_PC 5
`define PC_MASK_RST 16'hffc8

// ****************************************
// Sense modes
// ****************************************
`define SENSE_LOW 2'b00
`define SENSE_ANY 2'b01
`define SENSE_FALL 2'b10
`define SENSE_RISE 2'b11

// ****************************************
// Vector addresses
// ****************************************
`define VEC_RESET 5'h00
`define VEC_LINE_A 5'h01
`define VEC_PIN_CHANGE 5'h02
`define VEC_TB_MATCH_A 5'h03
`define VEC_TB_MATCH_B 5'h04
`define VEC_TB_OVERFLOW 5'h05
`define VEC_TA_OVERFLOW 5'h06
`define VEC_SERIAL_START 5'h07
`define VEC_SERIAL_OVF 5'h08
`define VEC_NVM_READY 5'h09
`define VEC_COMPARATOR 5'h0a
`define VEC_CONVERTER 5'h0b
`define VEC_WATCHDOG 5'h0c
`define VEC_LINE_B 5'h0d
`define VEC_TA_MATCH_A 5'h0e
`define VEC_TA_MATCH_B 5'h0f
`define VEC_CAPTURE 5'h10
`define VEC_TB_MATCH_D 5'h11
`define VEC_FAULT 5'h12
`define NUM_SOURCES 19

`endif

// ===== test/core_model.sv
module core_model (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Request side
  input wire logic irq_req_i,
  input wire logic [4:0] irq_vector_i,
  input wire logic slow_i,
  // Answer side
  output logic irq_ack_o,
  output logic [4:0] last_vec_o,
  output logic [7:0] ack_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] hold_reg;
  // Enters the routine a few cycles after the request stands
  always @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      hold_reg <= 4'h0;
      irq_ack_o <= 1'b0;
      last_vec_o <= 5'h00;
      ack_cnt_o <= 8'h00;
    end else begin
      irq_ack_o <= 1'b0;
      hold_reg <= irq_req_i ? hold_reg + 4'h1 : 4'h0;
      if (irq_req_i && hold_reg == (slow_i ? 4'h7 : 4'h3)) begin
        irq_ack_o <= 1'b1;
        hold_reg <= 4'h0;
        last_vec_o <= irq_vector_i;
        ack_cnt_o <= ack_cnt_o + 8'h01;
      end
    end
  end
endmodule // core_model

// ===== test/ext_irq_checker.sv
module ext_irq_checker (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  // Bus
  input wire logic s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o,
  input wire logic s_axi_rvalid_o, s_axi_rready_i,
  input wire logic [31:0] s_axi_rdata_o,
  // Pins, requests and core side
  input wire logic ext_req_line_a_i, irq_ack_i, irq_req_o, wake_o, global_irq_en_i,
  input wire logic [3:0] reset_cause_i,
  input wire logic [15:0] periph_req_i,
  input wire logic [4:0] irq_vector_o, fetch_addr_o,
  input wire logic [6:0] mcu_control_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  rst_vec_a: assert property ((|reset_cause_i) [*5] |-> fetch_addr_o == 5'h00)
    else $error("fetch address not at reset word");
  prio_low_a: assert property ((periph_req_i[0] && global_irq_en_i && !irq_ack_i) [*4] |->
    irq_req_o && irq_vector_o != 5'h00 && irq_vector_o <= 5'h03)
    else $error("lowest vector not served");
  ctl_ro_a: assert property (mcu_control_o[2] == 1'b0)
    else $error("read-only control bit set");
  lvl_wake_a: assert property ((mcu_control_o[1:0] == 2'b00 && !ext_req_line_a_i) [*8] |-> wake_o)
    else $error("low level gave no wake");
  b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data not held");
  r_next_a: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read answer late");
  ar_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read address taken during answer");
  cover property (irq_ack_i && irq_vector_o == 5'h0d);
  cover property (irq_ack_i && irq_vector_o == 5'h02);
  cover property (s_axi_rvalid_o && s_axi_rready_i);
endmodule // ext_irq_checker

bind ext_irq_and_vector_table ext_irq_checker u_ext_irq_checker (.ref_clk_i, .rst_b_i,
  .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o,
  .s_axi_rready_i, .s_axi_rdata_o, .ext_req_line_a_i, .irq_ack_i, .irq_req_o, .wake_o,
  .global_irq_en_i,
  .reset_cause_i, .periph_req_i, .irq_vector_o, .fetch_addr_o, .mcu_control_o);

// ===== test/tb_top.sv
`include "ext_irq_consts.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Signals
  // ****************************************
  logic ref_clk_i = 1'b0, rst_b_i = 1'b0, global_irq_en_i = 1'b1, slow = 1'b0;
  logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
  logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
  logic ext_req_line_a_i = 1'b1, ext_req_line_b_i = 1'b1;
  logic [11:0] s_axi_awaddr_i = 12'h000, s_axi_araddr_i = 12'h000;
  logic [31:0] s_axi_wdata_i = 32'h0000_0000, rd, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i = 4'hf, reset_cause_i = 4'h0;
  logic [15:0] pin_change_inputs_i = 16'h0000, periph_req_i = 16'h0000;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic irq_ack_i, irq_req_o, wake_o;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, resp;
  logic [4:0] irq_vector_o, fetch_addr_o, last_vec;
  logic [6:0] mcu_control_o;
  logic [7:0] ack_cnt, acks;
  int err_total = 0, n_checks = 0;
  initial begin
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  ext_irq_and_vector_table u_ext_irq_and_vector_table (.ref_clk_i, .rst_b_i, .s_axi_awaddr_i,
    .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
    .s_axi_rready_i, .ext_req_line_a_i, .ext_req_line_b_i, .pin_change_inputs_i,
    .reset_cause_i, .periph_req_i, .global_irq_en_i, .irq_ack_i, .irq_req_o, .irq_vector_o,
    .fetch_addr_o, .wake_o, .mcu_control_o);
  core_model u_core_model (.ref_clk_i, .rst_b_i, .irq_req_i(irq_req_o),
    .irq_vector_i(irq_vector_o), .slow_i(slow), .irq_ack_o(irq_ack_i), .last_vec_o(last_vec),
    .ack_cnt_o(ack_cnt));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end while (s_axi_bvalid_o !== 1'b1);
    resp = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
  endtask
  task automatic rd_reg(input logic [11:0] a);
    @(posedge ref_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end while (s_axi_rvalid_o !== 1'b1);
    rd = s_axi_rdata_o;
    resp = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
  endtask
  // Drives both lines to v0 for two cycles, then v1, and checks both edge flags
  task automatic lines(input logic v0, input logic v1, input logic exp);
    wr(`ADDR_REQ_FLAGS, 32'h0000_00c0);
    ext_req_line_a_i <= v0;
    ext_req_line_b_i <= v0;
    repeat (2) @(posedge ref_clk_i);
    ext_req_line_a_i <= v1;
    ext_req_line_b_i <= v1;
    repeat (10) @(posedge ref_clk_i);
    rd_reg(`ADDR_REQ_FLAGS);
    chk(rd[7:6], {exp, exp});
  endtask
  task automatic irq_chk(input logic [4:0] v);
    acks = ack_cnt;
    wait (ack_cnt != acks);
    chk(last_vec, v);
  endtask
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (12) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    rd_reg(`ADDR_MCU_CONTROL);
    chk(rd, 32'h0000_0000);
    rd_reg(`ADDR_PC_MASK);
    chk(rd, 32'h0000_ffc8);
    wr(`ADDR_MCU_CONTROL, 32'h0000_00ff);
    rd_reg(`ADDR_MCU_CONTROL);
    chk(rd, 32'h0000_007b);
    chk(mcu_control_o, 7'h7b);
    rd_reg(12'h200);
    chk(resp, 2'b10);
    wr(12'h204, 32'h0000_0001);
    chk(resp, 2'b10);
    for (int m = 1; m < 4; m++) begin
      wr(`ADDR_MCU_CONTROL, m);
      lines(1'b0, 1'b1, 1'b1);
      lines(1'b0, 1'b0, m != 3);
      lines(1'b1, 1'b1, m != 2);
    end
    wr(`ADDR_PC_MASK, 32'h0000_0001);
    for (int i = 1; i >= 0; i--) begin
      wr(`ADDR_REQ_FLAGS, 32'h0000_0020);
      pin_change_inputs_i <= pin_change_inputs_i ^ (16'h0001 << i);
      repeat (10) @(posedge ref_clk_i);
      rd_reg(`ADDR_REQ_FLAGS);
      chk(rd[5], i == 0);
    end
    // Status shows both lines high, pins 1:0 set and no vector pending
    rd_reg(`ADDR_STATUS);
    chk(rd, 32'h0000_01e0);
    wr(`ADDR_MCU_CONTROL, `SENSE_LOW);
    wr(`ADDR_REQ_FLAGS, 32'h0000_00e0);
    wr(`ADDR_REQ_ENABLE, 32'h0000_0040);
    ext_req_line_a_i <= 1'b0;
    irq_chk(`VEC_LINE_A);
    irq_chk(`VEC_LINE_A);
    periph_req_i <= 16'h0001;
    repeat (8) @(posedge ref_clk_i);
    chk(irq_vector_o, `VEC_LINE_A);
    ext_req_line_a_i <= 1'b1;
    for (int i = 0; i < 15; i++) begin
      periph_req_i <= 16'h0001 << i;
      repeat (8) @(posedge ref_clk_i);
      chk(irq_vector_o, i < 10 ? i + 3 : i + 4);
    end
    for (int i = 0; i < 4; i++) begin
      reset_cause_i <= 4'h1 << i;
      repeat (6) @(posedge ref_clk_i);
      chk(fetch_addr_o, `VEC_RESET);
    end
    reset_cause_i <= 4'h0;
    repeat (6) @(posedge ref_clk_i);
    chk(fetch_addr_o, `VEC_FAULT);
    periph_req_i <= 16'h0000;
    slow <= 1'b1;
    wr(`ADDR_MCU_CONTROL, `SENSE_FALL);
    wr(`ADDR_REQ_FLAGS, 32'h0000_00e0);
    wr(`ADDR_REQ_ENABLE, 32'h0000_00e0);
    ext_req_line_a_i <= 1'b0;
    ext_req_line_b_i <= 1'b0;
    irq_chk(`VEC_LINE_A);
    irq_chk(`VEC_LINE_B);
    pin_change_inputs_i <= 16'h0000;
    irq_chk(`VEC_PIN_CHANGE);
    repeat (6) @(posedge ref_clk_i);
    rd_reg(`ADDR_REQ_FLAGS);
    chk(rd[7:5], 3'b000);
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    err_total++;
    finish_test();
  end
endmodule // tb_top
